// [bench/test_tmc_top.sv]
// Self-checking testbench for the test-mode contact forcing block
`timescale 1ns/1ps
`include "tmc_cfg.svh"
module test_tmc_top
  import tmc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, trigger_op, test_led, irq, rerr, prev;
  logic [7:0] paddr, level, contact_in, input_report, out_operand, contact_out;
  logic [31:0] pwdata, prdata, rd;
  int miscompares, compares, cycles, n;

  // ==========================================================
  // Clock, design and field wiring
  always #5 pclk = ~pclk;
  // Short flash half period keeps the run brief
  tmc_top #(.FLASH_HALF_CYC(32'h4)) tmc_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_op(trigger_op),
    .contact_in(contact_in), .input_report(input_report), .out_operand(out_operand),
    .contact_out(contact_out), .test_led(test_led), .irq(irq));
  tmc_field tmc_field_inst (.pclk(pclk), .level(level), .contact_in(contact_in));

  // ==========================================================
  // Helpers
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask : tick

  // One APB transfer; holds the request until pready is seen high, then idles a cycle
  // A wait that never ends is left to the hang guard
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rchk

  // Reported input state for a 2-bit-per-input force word during a session
  function automatic logic [7:0] in_exp(input logic [15:0] f, input logic [7:0] pins);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = (f[2*i+:2] == `TMC_IN_OPEN) ? 1'b0 : (f[2*i+:2] == `TMC_IN_CLOSED) ? 1'b1 : pins[i];
    return r;
  endfunction : in_exp

  // Contact position during a session given operands and pre-session positions
  function automatic logic [7:0] out_exp(input logic [15:0] f, input logic [7:0] op,
    input logic [7:0] frz);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      case (f[2*i+:2])
        `TMC_OUT_ENERGIZE: r[i] = 1'b1;
        `TMC_OUT_DEENERGIZE: r[i] = 1'b0;
        `TMC_OUT_FREEZE: r[i] = frz[i];
        default: r[i] = op[i];
      endcase
    return r;
  endfunction : out_exp

  // ==========================================================
  // Hang guard, well above the roughly 150 cycles the tests need
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      miscompares++;
      complete_run();
    end
  end

  // ==========================================================
  // Tests
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    trigger_op = 1'b0;
    level = 8'h00;
    out_operand = 8'h00;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    tick(4);
    presetn <= 1'b1;
    tick(1);
    // Register map, read-only and unmapped places
    rchk("ctrl", `TMC_OFF_CTRL, 32'h0);
    rchk("in_force", `TMC_OFF_IN_FORCE, 32'h0);
    rchk("out_force", `TMC_OFF_OUT_FORCE, 32'h0);
    apb(1'b1, `TMC_OFF_STATUS, 32'hffff_ffff);
    rchk("status", `TMC_OFF_STATUS, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk("slverr", 32'h1, rerr);
    chk("unmapped", 32'h0, rd);
    rchk("irq_clr", `TMC_OFF_IRQ_CLR, 32'h0);
    $display("test registers done");
    // Forces set but no session: trigger alone without enable starts nothing
    level <= 8'h5a;
    out_operand <= 8'h3c;
    trigger_op <= 1'b1;
    apb(1'b1, `TMC_OFF_IN_FORCE, 32'hc924); // input 0 left live, input 7 on spare code
    apb(1'b1, `TMC_OFF_OUT_FORCE, 32'he4e4);
    apb(1'b1, `TMC_OFF_IRQ_EN, 32'h3);
    apb(1'b1, `TMC_OFF_CTRL, 32'h2);
    tick(5);
    rchk("idle", `TMC_OFF_STATUS, 32'h0);
    chk("in idle", 32'h5a, input_report);
    chk("out idle", 32'h3c, contact_out);
    chk("led idle", 32'h0, test_led);
    trigger_op <= 1'b0;
    $display("test no_session done");
    // Fixed trigger session
    apb(1'b1, `TMC_OFF_CTRL, 32'h3);
    tick(3);
    apb(1'b0, `TMC_OFF_STATUS, 32'h0);
    chk("active", 32'h1, rd[0]);
    chk("in forced", in_exp(16'hc924, 8'h5a), input_report);
    out_operand <= 8'hc3;
    level <= 8'ha5;
    tick(5);
    chk("in live bits", in_exp(16'hc924, 8'ha5), input_report);
    chk("out forced", out_exp(16'he4e4, 8'hc3, 8'h3c), contact_out);
    rchk("irq start", `TMC_OFF_IRQ_STAT, 32'h1);
    chk("irq line", 32'h1, irq);
    rchk("bus in session", `TMC_OFF_CTRL, 32'h3);
    n = 0;
    prev = test_led;
    repeat (16)
    begin
      @(posedge pclk);
      if (test_led !== prev)
        n++;
      prev = test_led;
    end
    chk("led flashing", 32'h1, n >= 3);
    apb(1'b1, `TMC_OFF_IRQ_CLR, 32'h1);
    rchk("irq cleared", `TMC_OFF_IRQ_STAT, 32'h0);
    apb(1'b1, `TMC_OFF_IN_FORCE, 32'h0);
    tick(5);
    chk("in restored", 32'ha5, input_report);
    apb(1'b1, `TMC_OFF_IN_FORCE, 32'hc924);
    apb(1'b1, `TMC_OFF_CTRL, 32'h2);
    tick(5);
    rchk("ended", `TMC_OFF_STATUS, 32'h0);
    chk("in released", 32'ha5, input_report);
    chk("out released", 32'hc3, contact_out);
    rchk("irq end", `TMC_OFF_IRQ_STAT, 32'h2);
    apb(1'b1, `TMC_OFF_IRQ_CLR, 32'h2);
    $display("test fixed_session done");
    // Operand trigger session with interrupt masked
    apb(1'b1, `TMC_OFF_IRQ_EN, 32'h0);
    apb(1'b1, `TMC_OFF_CTRL, 32'h1);
    tick(3);
    apb(1'b0, `TMC_OFF_STATUS, 32'h0);
    chk("no operand", 32'h0, rd[0]);
    trigger_op <= 1'b1;
    tick(3);
    apb(1'b0, `TMC_OFF_STATUS, 32'h0);
    chk("operand start", 32'h1, rd[0]);
    out_operand <= 8'h00;
    tick(4);
    chk("in forced op", in_exp(16'hc924, 8'ha5), input_report);
    chk("out frozen op", out_exp(16'he4e4, 8'h00, 8'hc3), contact_out);
    chk("irq masked", 32'h0, irq);
    rchk("irq stat masked", `TMC_OFF_IRQ_STAT, 32'h1);
    trigger_op <= 1'b0;
    tick(4);
    apb(1'b0, `TMC_OFF_STATUS, 32'h0);
    chk("operand end", 32'h0, rd[0]);
    chk("out live end", 32'h00, contact_out);
    chk("led off", 32'h0, test_led);
    $display("test operand_session done");
    complete_run();
  end
endmodule : test_tmc_top

// [bench/tmc_field.sv]
// Field wiring model that drives the contact input terminals
`timescale 1ns/1ps
module tmc_field
  import tmc_pkg::*;
(
  input wire logic pclk,
  input wire logic [7:0] level,
  output logic [7:0] contact_in
);
  // ==========================================================
  // Terminal voltages
  // Wiring changes just after an edge, so the design's first flop never races it
  always @(posedge pclk)
    contact_in <= level;
endmodule : tmc_field

// [design/tmc_cfg.svh]
// Constants for the test-mode contact forcing block
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

// ==========================================================
// Sizes
`define TMC_N_IN 8
`define TMC_N_OUT 8
`define TMC_AW 8

// ==========================================================
// Register byte addresses
`define TMC_OFF_CTRL 8'h00
`define TMC_OFF_STATUS 8'h04
`define TMC_OFF_IN_FORCE 8'h08
`define TMC_OFF_OUT_FORCE 8'h0c
`define TMC_OFF_IN_STATE 8'h10
`define TMC_OFF_OUT_STATE 8'h14
`define TMC_OFF_IRQ_STAT 8'h18
`define TMC_OFF_IRQ_EN 8'h1c
`define TMC_OFF_IRQ_CLR 8'h20

// ==========================================================
// Field positions
`define TMC_CTRL_EN_BIT 0
`define TMC_CTRL_FIXED_BIT 1
`define TMC_STATUS_ACT_BIT 0
`define TMC_STATUS_LED_BIT 1
`define TMC_IRQ_START_BIT 0
`define TMC_IRQ_END_BIT 1
`define TMC_IRQ_W 2

// ==========================================================
// Reset values
`define TMC_CTRL_RST 2'h0
`define TMC_FORCE_RST 16'h0000
`define TMC_IRQ_RST 2'h0
`define TMC_DATA_ZERO 32'h0000_0000

// ==========================================================
// Force selection encodings
`define TMC_IN_LIVE 2'h0
`define TMC_IN_OPEN 2'h1
`define TMC_IN_CLOSED 2'h2
`define TMC_OUT_LIVE 2'h0
`define TMC_OUT_ENERGIZE 2'h1
`define TMC_OUT_DEENERGIZE 2'h2
`define TMC_OUT_FREEZE 2'h3

// ==========================================================
// Timing: indicator half period
`define TMC_CLK_HZ 100000000
`define TMC_FLASH_HALF_MS 250
`define TMC_FLASH_HALF_CYC (`TMC_FLASH_HALF_MS * (`TMC_CLK_HZ / 1000))

`endif

// [design/tmc_flash.sv]
// Front-panel test indicator flasher
`timescale 1ns/1ps
`include "tmc_cfg.svh"
module tmc_flash
  import tmc_pkg::*;
#(
  parameter logic [31:0] HALF_CYC = 32'(`TMC_FLASH_HALF_CYC)
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  output logic led
);

  logic [31:0] cnt;

  // ==========================================================
  // Half-period counter, held at zero outside a session
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 32'h0000_0000;
      led <= 1'b0;
    end
    else if (!active)
    begin
      cnt <= 32'h0000_0000;
      led <= 1'b0;
    end
    else if (cnt == HALF_CYC - 32'h0000_0001)
    begin
      cnt <= 32'h0000_0000;
      led <= !led;
    end
    else
    begin
      cnt <= cnt + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Checks
  property p_led_toggle;
    @(posedge pclk) disable iff (!presetn)
    active && (cnt == HALF_CYC - 32'h0000_0001) |=> (led != $past(led));
  endproperty
  a_led_toggle: assert property (p_led_toggle)
    else $error("indicator did not toggle at half period");

  property p_led_dark;
    @(posedge pclk) disable iff (!presetn)
    !active |=> !led;
  endproperty
  a_led_dark: assert property (p_led_dark)
    else $error("indicator lit outside session");

endmodule : tmc_flash

// [design/tmc_pkg.sv]
// Types shared by the test-mode contact forcing block
package tmc_pkg;
`include "tmc_cfg.svh"

  // ==========================================================
  // Force selections
  typedef enum logic [1:0] {
    TMC_IN_MODE_LIVE = `TMC_IN_LIVE,
    TMC_IN_MODE_OPEN = `TMC_IN_OPEN,
    TMC_IN_MODE_CLOSED = `TMC_IN_CLOSED
  } tmc_in_mode_t;

  typedef enum logic [1:0] {
    TMC_OUT_MODE_LIVE = `TMC_OUT_LIVE,
    TMC_OUT_MODE_ENERGIZE = `TMC_OUT_ENERGIZE,
    TMC_OUT_MODE_DEENERGIZE = `TMC_OUT_DEENERGIZE,
    TMC_OUT_MODE_FREEZE = `TMC_OUT_FREEZE
  } tmc_out_mode_t;

  // ==========================================================
  // Session state
  typedef enum logic {TMC_IDLE, TMC_ACTIVE} tmc_state_t;

  // Control word: session enable and trigger source
  typedef struct packed {
    logic fixed_on;
    logic enable;
  } tmc_ctrl_t;

  // Interrupt events
  typedef struct packed {
    logic ended;
    logic started;
  } tmc_irq_t;
endpackage : tmc_pkg

// [design/tmc_top.sv]
// Test-mode controller with contact input and output forcing, APB slave
//
// Function
// - A session runs only while the enable bit is set and the chosen trigger is one.
// - With the fixed-on trigger, the session starts when the enable bit goes from 0 to 1.
// - With the operand trigger and enable set, the session starts when the operand goes to one.
// - While the session runs the test indicator flashes.
// - Protection, logic and communication signals pass untouched during a session.
// - A session alters only contacts: inputs open/closed/live, outputs open/closed/frozen/live.
// - Each contact input and output has its own override selection, applied independently.
// - An input with no override keeps reporting its sensed terminal state.
// - An input forced open reports zero for the whole session.
// - An input forced closed reports one for the whole session.
// - All inputs run normally once every input override is back to disabled.
// - An output with no override follows its controlling operand.
// - An output set to energize or de-energize stays closed or open for the session.
// - A frozen output keeps the position it had just before the session began.
`timescale 1ns/1ps
`include "tmc_cfg.svh"
module tmc_top
  import tmc_pkg::*;
#(
  parameter logic [31:0] FLASH_HALF_CYC = 32'(`TMC_FLASH_HALF_CYC)
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TMC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_op,
  input wire logic [`TMC_N_IN-1:0] contact_in,
  output logic [`TMC_N_IN-1:0] input_report,
  input wire logic [`TMC_N_OUT-1:0] out_operand,
  output logic [`TMC_N_OUT-1:0] contact_out,
  output logic test_led,
  output logic irq
);

  // ==========================================================
  // Decode helpers
  function automatic logic reg_hit(input logic [`TMC_AW-1:0] a, input logic [`TMC_AW-1:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit
  // Reported level of one input under its selection
  function automatic logic in_apply(input logic [1:0] mode, input logic live);
    unique case (mode)
      `TMC_IN_OPEN: in_apply = 1'b0;
      `TMC_IN_CLOSED: in_apply = 1'b1;
      default: in_apply = live; // Spare code behaves as live
    endcase
  endfunction : in_apply

  // Contact position of one output under its selection
  function automatic logic out_apply(input logic [1:0] mode, input logic op, input logic frz);
    unique case (mode)
      `TMC_OUT_ENERGIZE: out_apply = 1'b1;
      `TMC_OUT_DEENERGIZE: out_apply = 1'b0;
      `TMC_OUT_FREEZE: out_apply = frz;
      default: out_apply = op;
    endcase
  endfunction : out_apply

  // ==========================================================
  // Registers and state
  tmc_ctrl_t ctrl;
  logic [2*`TMC_N_IN-1:0] in_force;
  logic [2*`TMC_N_OUT-1:0] out_force;
  tmc_irq_t irq_stat;
  tmc_irq_t irq_en;
  tmc_state_t state;
  logic active;
  logic sess_req;
  logic [`TMC_N_IN-1:0] in_meta;
  logic [`TMC_N_IN-1:0] in_sync;
  logic [`TMC_N_OUT-1:0] frz;
  logic wr_en;
  logic rd_en;
  logic hit;
  tmc_irq_t ev;
  logic [31:0] next_rdata;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign active = (state == TMC_ACTIVE);

  // Trigger evaluation: fixed-on counts as logic one
  assign sess_req = ctrl.enable && (ctrl.fixed_on || trigger_op);

  // ==========================================================
  // Control and force registers written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= tmc_ctrl_t'(`TMC_CTRL_RST);
      in_force <= `TMC_FORCE_RST;
      out_force <= `TMC_FORCE_RST;
      irq_en <= tmc_irq_t'(`TMC_IRQ_RST);
    end
    else if (wr_en)
    begin
      if (reg_hit(paddr, `TMC_OFF_CTRL))
      begin
        ctrl.enable <= pwdata[`TMC_CTRL_EN_BIT];
        ctrl.fixed_on <= pwdata[`TMC_CTRL_FIXED_BIT];
      end
      if (reg_hit(paddr, `TMC_OFF_IN_FORCE))
        in_force <= pwdata[2*`TMC_N_IN-1:0];
      if (reg_hit(paddr, `TMC_OFF_OUT_FORCE))
        out_force <= pwdata[2*`TMC_N_OUT-1:0];
      if (reg_hit(paddr, `TMC_OFF_IRQ_EN))
        irq_en <= tmc_irq_t'(pwdata[`TMC_IRQ_W-1:0]);
    end
  end

  // ==========================================================
  // Session state machine; level-driven so both trigger kinds share it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= TMC_IDLE;
    else
    begin
      unique case (state)
        TMC_IDLE:
          if (sess_req)
            state <= TMC_ACTIVE;
        TMC_ACTIVE:
          if (!sess_req)
            state <= TMC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Contact input synchroniser; terminals are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_meta <= '0;
      in_sync <= '0;
    end
    else
    begin
      in_meta <= contact_in;
      in_sync <= in_meta;
    end
  end

  // ==========================================================
  // Per-channel forcing; only contacts are touched, all other signals bypass this block
  genvar gi;
  generate
    for (gi = 0; gi < `TMC_N_IN; gi = gi + 1)
    begin : g_in
      // Inputs report live terminals unless a session forces them
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          input_report[gi] <= 1'b0;
        else if (active)
          input_report[gi] <= in_apply(in_force[2*gi +: 2], in_sync[gi]);
        else
          input_report[gi] <= in_sync[gi];
      end

      property p_in_open;
        @(posedge pclk) disable iff (!presetn)
        active && (in_force[2*gi +: 2] == `TMC_IN_OPEN) |=> !input_report[gi];
      endproperty
      a_in_open: assert property (p_in_open)
        else $error("input forced open did not report zero");

      property p_in_closed;
        @(posedge pclk) disable iff (!presetn)
        active && (in_force[2*gi +: 2] == `TMC_IN_CLOSED) |=> input_report[gi];
      endproperty
      a_in_closed: assert property (p_in_closed)
        else $error("input forced closed did not report one");

      property p_in_live;
        @(posedge pclk) disable iff (!presetn)
        (!active || (in_force[2*gi +: 2] == `TMC_IN_LIVE)) |=> input_report[gi] == $past(in_sync[gi]);
      endproperty
      a_in_live: assert property (p_in_live)
        else $error("unforced input did not follow its terminal");
    end

    for (gi = 0; gi < `TMC_N_OUT; gi = gi + 1)
    begin : g_out
      // Snapshot tracks the position the contact takes next, so freezing causes no glitch
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          frz[gi] <= 1'b0;
        else if (!active)
          frz[gi] <= out_operand[gi];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          contact_out[gi] <= 1'b0;
        else if (active)
          contact_out[gi] <= out_apply(out_force[2*gi +: 2], out_operand[gi], frz[gi]);
        else
          contact_out[gi] <= out_operand[gi];
      end

      property p_out_energize;
        @(posedge pclk) disable iff (!presetn)
        active && (out_force[2*gi +: 2] == `TMC_OUT_ENERGIZE) |=> contact_out[gi];
      endproperty
      a_out_energize: assert property (p_out_energize)
        else $error("energized output not closed");

      property p_out_deenergize;
        @(posedge pclk) disable iff (!presetn)
        active && (out_force[2*gi +: 2] == `TMC_OUT_DEENERGIZE) |=> !contact_out[gi];
      endproperty
      a_out_deenergize: assert property (p_out_deenergize)
        else $error("de-energized output not open");

      property p_out_freeze;
        @(posedge pclk) disable iff (!presetn)
        active && $past(active) && (out_force[2*gi +: 2] == `TMC_OUT_FREEZE)
          |=> contact_out[gi] == $past(contact_out[gi], 2);
      endproperty
      a_out_freeze: assert property (p_out_freeze)
        else $error("frozen output moved during session");

      property p_out_live;
        @(posedge pclk) disable iff (!presetn)
        (!active || (out_force[2*gi +: 2] == `TMC_OUT_LIVE)) |=> contact_out[gi] == $past(out_operand[gi]);
      endproperty
      a_out_live: assert property (p_out_live)
        else $error("live output did not follow its operand");
    end
  endgenerate

  // ==========================================================
  // Indicator
  tmc_flash #(
    .HALF_CYC(FLASH_HALF_CYC)
  ) u_flash (
    .pclk(pclk),
    .presetn(presetn),
    .active(active),
    .led(test_led)
  );

  // ==========================================================
  // Sticky interrupt events; a new event wins over a same-cycle clear
  assign ev.started = (state == TMC_IDLE) && sess_req;
  assign ev.ended = active && !sess_req;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat <= tmc_irq_t'(`TMC_IRQ_RST);
    else if (wr_en && reg_hit(paddr, `TMC_OFF_IRQ_CLR))
      irq_stat <= (irq_stat & ~tmc_irq_t'(pwdata[`TMC_IRQ_W-1:0])) | ev;
    else
      irq_stat <= irq_stat | ev;
  end

  assign irq = |(irq_stat & irq_en);

  // ==========================================================
  // Read path; zero wait states, unmapped addresses answer with an error
  always_comb
  begin
    next_rdata = `TMC_DATA_ZERO;
    hit = 1'b1;
    unique case (paddr)
      `TMC_OFF_CTRL:
      begin
        next_rdata[`TMC_CTRL_EN_BIT] = ctrl.enable;
        next_rdata[`TMC_CTRL_FIXED_BIT] = ctrl.fixed_on;
      end
      `TMC_OFF_STATUS:
      begin
        next_rdata[`TMC_STATUS_ACT_BIT] = active;
        next_rdata[`TMC_STATUS_LED_BIT] = test_led;
      end
      `TMC_OFF_IN_FORCE: next_rdata[2*`TMC_N_IN-1:0] = in_force;
      `TMC_OFF_OUT_FORCE: next_rdata[2*`TMC_N_OUT-1:0] = out_force;
      `TMC_OFF_IN_STATE: next_rdata[`TMC_N_IN-1:0] = input_report;
      `TMC_OFF_OUT_STATE: next_rdata[`TMC_N_OUT-1:0] = contact_out;
      `TMC_OFF_IRQ_STAT: next_rdata[`TMC_IRQ_W-1:0] = irq_stat;
      `TMC_OFF_IRQ_EN: next_rdata[`TMC_IRQ_W-1:0] = irq_en;
      `TMC_OFF_IRQ_CLR: next_rdata = `TMC_DATA_ZERO; // Write-only
      default: hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup phase so it is ready in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= `TMC_DATA_ZERO;
    else if (rd_en && !penable)
      prdata <= next_rdata;
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ==========================================================
  // Session checks
  property p_active_cause;
    @(posedge pclk) disable iff (!presetn)
    active |-> $past(sess_req);
  endproperty
  a_active_cause: assert property (p_active_cause)
    else $error("session active without enable and trigger");

  property p_fixed_start;
    @(posedge pclk) disable iff (!presetn)
    $rose(ctrl.enable) && ctrl.fixed_on |=> active;
  endproperty
  a_fixed_start: assert property (p_fixed_start)
    else $error("fixed trigger did not start session on enable");

  property p_oper_start;
    @(posedge pclk) disable iff (!presetn)
    ctrl.enable && !ctrl.fixed_on && $rose(trigger_op) |=> active;
  endproperty
  a_oper_start: assert property (p_oper_start)
    else $error("operand trigger did not start session");

  property p_end_release;
    @(posedge pclk) disable iff (!presetn)
    $fell(active) |=> (contact_out == $past(out_operand)) && (input_report == $past(in_sync));
  endproperty
  a_end_release: assert property (p_end_release)
    else $error("overrides not released at session end");

endmodule : tmc_top
